/* File: sfa_consts.vh */
`ifndef SFA_CONSTS_VH
`define SFA_CONSTS_VH

// bus addresses (7 bits)
`define SFA_ADDR_POINTER 7'h0C
`define SFA_ADDR_CHAN_A_LO 7'h50
`define SFA_ADDR_CHAN_B_LO 7'h51
`define SFA_ADDR_CHAN_A_HI 7'h52
`define SFA_ADDR_CHAN_B_HI 7'h53

// fault status byte field positions
`define SFA_BIT_CATASTROPHIC 7
`define SFA_BIT_SOCKET_A_LOGIC 6
`define SFA_BIT_SOCKET_A_PROG 5
`define SFA_BIT_SOCKET_B_LOGIC 4
`define SFA_BIT_SOCKET_B_PROG 3
`define SFA_BIT_CHANNEL_COUNT 2

// reset values and fixed fields
`define SFA_FAULT_STATUS_RESET 5'h00
`define SFA_CHANNEL_COUNT_DUAL 1'b0
`define SFA_RETURN_ADDR_RESET 8'h00

// overcurrent qualification time
`define SFA_OVERCURRENT_MIN_NS 2000
`define SFA_CLK_PERIOD_NS 10
`define SFA_OVERCURRENT_CYCLES ((`SFA_OVERCURRENT_MIN_NS + `SFA_CLK_PERIOD_NS - 1) / `SFA_CLK_PERIOD_NS)

`endif

/* File: sfa_smbus_fault_alert.v */
`timescale 1ns/10ps
`include "sfa_consts.vh"

// What this block does
// - valid read address: acknowledge, then transmit bits
// - repeated start after write allows direction change
// - never master; only pulls alert low
// - alert only for overcurrent, supply undervoltage, lockout, thermal
// - power-on reset clears status, alert and sequencer; return address follows strap
// - fault latches alert low and data
// - pointer read releases alert, sends address
// - persisting fault reasserts alert, no reload
// - channel A read shifts status, reloads bits from live unmasked faults
// - pointer byte bits 7:1 hold return address
// - bit 7 latches catastrophic fault
// - bits 6:3 latch per-supply socket faults
// - bit 2 reads 0; bits 1:0 zero
// - alerting slaves arbitrate, lower address wins
// - arbitration loser no acknowledge, keeps alert
// - overcurrent over 2 us needed for alert
// - fault mask blocks alert raising
// - unmatched address: no acknowledge, ignore until start
module sfa_smbus_fault_alert (
  input wire ref_clk,
  input wire rst,
  input wire bus_clock_in,
  input wire bus_data_in,
  output reg bus_data_out,
  output reg bus_data_oe,
  output wire alert_out,
  output wire alert_oe,
  input wire address_select,
  input wire fault_alert_mask,
  input wire thermal_overload,
  input wire undervoltage_lockout,
  input wire [3:0] supply_overcurrent,
  input wire [3:0] supply_undervoltage,
  output wire [7:0] fault_status,
  output wire [7:0] alert_return_address
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ADDR_ACK = 3'h2;
  localparam ST_WRITE = 3'h3;
  localparam ST_WRITE_ACK = 3'h4;
  localparam ST_READ = 3'h5;
  localparam ST_READ_ACK = 3'h6;
  localparam ST_IGNORE = 3'h7;
  localparam integer OC_CYCLES_FULL = `SFA_OVERCURRENT_CYCLES;
  localparam [8:0] OC_CYCLES = OC_CYCLES_FULL[8:0]; // qualification count fits in 9 bits

  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [3:0] oc_sync1;
  reg [3:0] oc_sync2;
  reg [3:0] uv_sync1;
  reg [3:0] uv_sync2;
  reg [1:0] cat_sync1;
  reg [1:0] cat_sync2;
  reg mask_sync1;
  reg mask_sync2;
  reg adr_sync1;
  reg adr_sync2;
  reg scl_prev;
  reg sda_prev;
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] shift_out;
  reg pointer_read;
  reg lost_arb;
  reg alert_latched;
  reg [4:0] fault_bits;
  reg [4:0] fault_live;
  reg read_pending_clear;
  reg pointer_pending_clear;
  wire [3:0] oc_long;
  wire [3:0] socket_fault;
  wire catastrophic;
  wire [6:0] own_addr;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;
  wire any_fault;
  wire addr_match;
  wire is_read;

  // two-stage synchronisers for every outside input
  always @(posedge ref_clk) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      oc_sync1 <= 4'h0;
      oc_sync2 <= 4'h0;
      uv_sync1 <= 4'h0;
      uv_sync2 <= 4'h0;
      cat_sync1 <= 2'h0;
      cat_sync2 <= 2'h0;
      mask_sync1 <= 1'b0;
      mask_sync2 <= 1'b0;
      adr_sync1 <= 1'b0;
      adr_sync2 <= 1'b0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], bus_clock_in};
      sda_sync <= {sda_sync[0], bus_data_in};
      oc_sync1 <= supply_overcurrent;
      oc_sync2 <= oc_sync1;
      uv_sync1 <= supply_undervoltage;
      uv_sync2 <= uv_sync1;
      cat_sync1 <= {thermal_overload, undervoltage_lockout};
      cat_sync2 <= cat_sync1;
      mask_sync1 <= fault_alert_mask;
      mask_sync2 <= mask_sync1;
      adr_sync1 <= address_select;
      adr_sync2 <= adr_sync1;
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // bus edges and conditions; data is sampled on clock rising edges only
  assign scl_rise = scl_sync[1] & ~scl_prev;
  assign scl_fall = ~scl_sync[1] & scl_prev;
  assign start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_cond = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];

  // per-supply overcurrent qualifier; short glitches are filtered out
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : oc_filter
      reg [8:0] oc_count;
      always @(posedge ref_clk) begin
        if (rst || !oc_sync2[g]) begin
          oc_count <= 9'h000;
        end else if (oc_count != OC_CYCLES) begin
          oc_count <= oc_count + 9'h001;
        end
      end
      assign oc_long[g] = (oc_count == OC_CYCLES);
    end
  endgenerate

  // live fault sources, ordered to the status byte's bits 7..3
  assign socket_fault = oc_long | uv_sync2;
  assign catastrophic = |cat_sync2;
  always @* begin
    fault_live = {catastrophic, socket_fault[0], socket_fault[1], socket_fault[2],
      socket_fault[3]};
  end
  assign any_fault = |fault_live & ~mask_sync2;

  // return address is the channel A address for the strap level
  assign own_addr = adr_sync2 ? `SFA_ADDR_CHAN_A_HI : `SFA_ADDR_CHAN_A_LO;
  assign addr_match = (shift_in[7:1] == `SFA_ADDR_POINTER) ? alert_latched :
    (shift_in[7:1] == `SFA_ADDR_CHAN_A_LO) ? ~adr_sync2 :
    (shift_in[7:1] == `SFA_ADDR_CHAN_B_LO) ? ~adr_sync2 :
    (shift_in[7:1] == `SFA_ADDR_CHAN_A_HI) ? adr_sync2 :
    (shift_in[7:1] == `SFA_ADDR_CHAN_B_HI) ? adr_sync2 : 1'b0;
  assign is_read = shift_in[0];

  // fault latches and alert; new faults set over any pending clear
  always @(posedge ref_clk) begin
    if (rst) begin
      fault_bits <= `SFA_FAULT_STATUS_RESET;
      alert_latched <= 1'b0;
    end else begin
      if (read_pending_clear) begin
        fault_bits <= fault_live & {5{~mask_sync2}};
      end else if (!alert_latched && any_fault && fault_bits == 5'h00) begin
        fault_bits <= fault_live;
      end
      if (any_fault) begin
        alert_latched <= 1'b1;
      end else if (pointer_pending_clear) begin
        alert_latched <= 1'b0;
      end
    end
  end

  // fault status byte: bit 2 dual part, bits 1:0 reserved zero
  assign fault_status = {fault_bits, `SFA_CHANNEL_COUNT_DUAL, 2'b00};
  assign alert_return_address = {own_addr, 1'b0};
  assign alert_out = 1'b0;
  assign alert_oe = alert_latched;

  // slave transfer sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      pointer_read <= 1'b0;
      lost_arb <= 1'b0;
      bus_data_out <= 1'b0;
      bus_data_oe <= 1'b0;
      read_pending_clear <= 1'b0;
      pointer_pending_clear <= 1'b0;
    end else begin
      read_pending_clear <= 1'b0;
      pointer_pending_clear <= 1'b0;
      if (start_cond) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        bus_data_oe <= 1'b0;
        lost_arb <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        bus_data_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            bus_data_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_in <= {shift_in[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (addr_match) begin
                bus_data_oe <= 1'b1;
                state <= ST_ADDR_ACK;
              end else begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (is_read) begin
                pointer_read <= (shift_in[7:1] == `SFA_ADDR_POINTER);
                if (shift_in[7:1] == `SFA_ADDR_POINTER) begin
                  shift_out <= {own_addr, 1'b0};
                end else begin
                  shift_out <= fault_status;
                  read_pending_clear <= 1'b1;
                end
                state <= ST_READ;
              end else begin
                bus_data_oe <= 1'b0;
                state <= ST_WRITE;
              end
            end
          end
          ST_WRITE: begin
            // command byte counted and acknowledged; its bits are not stored or decoded
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bus_data_oe <= 1'b1;
              state <= ST_WRITE_ACK;
            end
          end
          ST_WRITE_ACK: begin
            if (scl_fall) begin
              bus_data_oe <= 1'b0;
              state <= ST_IGNORE;
            end
          end
          ST_READ: begin
            // open drain: drive only for zero bits
            bus_data_oe <= ~shift_out[7] & ~lost_arb;
            if (scl_rise) begin
              if (pointer_read && shift_out[7] && !sda_sync[1]) begin
                lost_arb <= 1'b1;
              end
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              shift_out <= {shift_out[6:0], 1'b0};
              if (lost_arb) begin
                bus_data_oe <= 1'b0;
                state <= ST_IGNORE;
              end else if (bit_cnt == 4'h8) begin
                bus_data_oe <= 1'b0;
                // alert drops only once the whole address went out unbeaten
                pointer_pending_clear <= pointer_read;
                state <= ST_READ_ACK;
              end
            end
          end
          ST_READ_ACK: begin
            // single byte per read; the master's acknowledge bit ends it whatever its value
            bus_data_oe <= 1'b0;
            if (scl_rise) begin
              state <= ST_IGNORE;
            end
          end
          ST_IGNORE: begin
            bus_data_oe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: sfa_checker.sv */
`timescale 1ns/10ps
// port checks; the bench keeps the mask still around fault events
module sfa_checker (
  input wire ref_clk,
  input wire rst,
  input wire bus_clock_in,
  input wire bus_data_in,
  input wire bus_data_out,
  input wire bus_data_oe,
  input wire alert_out,
  input wire alert_oe,
  input wire fault_alert_mask,
  input wire thermal_overload,
  input wire undervoltage_lockout,
  input wire [3:0] supply_overcurrent,
  input wire [3:0] supply_undervoltage,
  input wire [7:0] fault_status
);
  // no fault source of any kind is active
  wire no_cause = !(thermal_overload | undervoltage_lockout | (|supply_overcurrent)
    | (|supply_undervoltage));
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_OPEN_DRAIN: assert property (!bus_data_out && !alert_out)
    else $error("open drain pin driven high");
  AST_RESERVED: assert property (fault_status[2:0] == 3'h0)
    else $error("fixed status bits not zero");
  AST_RESET_CLEAR: assert property ($fell(rst) |-> !bus_data_oe && !alert_oe && fault_status == 8'h00)
    else $error("state not clear after reset");
  AST_DRIVE_CLK_LOW: assert property ($changed(bus_data_oe) |-> !bus_clock_in)
    else $error("data drive changed with clock high");
  AST_ALERT_HOLD: assert property ((alert_oe && bus_clock_in && bus_data_in) [*8] |=> alert_oe)
    else $error("alert dropped on an idle bus");
  AST_MASK: assert property ($rose(alert_oe) |-> !$past(fault_alert_mask))
    else $error("alert raised while masked");
  AST_CAUSE: assert property (no_cause [*8] |=> !$rose(alert_oe))
    else $error("alert raised with no fault");
  AST_NO_RELOAD: assert property (bus_clock_in && $past(fault_status[7:3]) != 5'h00 |-> $stable(fault_status))
    else $error("latched fault bits reloaded");
endmodule
bind sfa_smbus_fault_alert sfa_checker i_sfa_checker (.ref_clk, .rst, .bus_clock_in, .bus_data_in,
  .bus_data_out, .bus_data_oe, .alert_out, .alert_oe, .fault_alert_mask, .thermal_overload,
  .undervoltage_lockout, .supply_overcurrent, .supply_undervoltage, .fault_status);

/* File: sfa_host_model.sv */
`timescale 1ns/10ps
// bus master; the wire is resolved here, the pull-up wins when nobody pulls
module sfa_host_model (
  input wire ref_clk,
  input wire dev_data_oe,
  output reg bus_clock,
  output wire bus_data
);
  reg pull = 1'b0;
  reg [7:0] rival = 8'hFF; // a lower slave answering a pointer read
  initial bus_clock = 1'b1;
  assign bus_data = ~(pull | dev_data_oe);
  task tk(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one bit of 13 cycles; data moves mid-low so no false start is seen
  task wbit(input b, output s);
    begin
      tk(4);
      pull <= ~b;
      tk(3);
      bus_clock <= 1'b1;
      tk(3);
      s = bus_data;
      tk(3);
      bus_clock <= 1'b0;
    end
  endtask
  // start, also used as repeated start with the clock low
  task start;
    begin
      tk(4);
      pull <= 1'b0;
      tk(3);
      bus_clock <= 1'b1;
      tk(6);
      pull <= 1'b1;
      tk(6);
      bus_clock <= 1'b0;
    end
  endtask
  task stop;
    begin
      tk(4);
      pull <= 1'b1;
      tk(3);
      bus_clock <= 1'b1;
      tk(6);
      pull <= 1'b0;
      tk(6);
    end
  endtask
  // address byte with direction bit, then one data byte
  task xfer(input [7:0] a, input [7:0] wd, output ack, output [7:0] rd);
    integer i;
    reg s;
    begin
      start;
      for (i = 7; i >= 0; i = i - 1)
        wbit(a[i], s);
      wbit(1'b1, s);
      ack = ~s;
      for (i = 7; i >= 0; i = i - 1)
        wbit(a[0] ? rival[i] : wd[i], rd[i]);
      wbit(1'b1, s);
    end
  endtask
endmodule

/* File: sfa_smbus_fault_alert_tb.sv */
`timescale 1ns/10ps
module sfa_smbus_fault_alert_tb;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg address_select = 1'b0;
  reg fault_alert_mask = 1'b0;
  reg thermal_overload = 1'b0;
  reg undervoltage_lockout = 1'b0;
  reg [3:0] supply_overcurrent = 4'h0;
  reg [3:0] supply_undervoltage = 4'h0;
  wire bus_clock_in;
  wire bus_data_in;
  wire bus_data_out;
  wire bus_data_oe;
  wire alert_out;
  wire alert_oe;
  wire [7:0] fault_status;
  wire [7:0] alert_return_address;
  integer failures = 0;
  integer n_compared = 0;
  reg ack;
  reg [7:0] rd;
  sfa_smbus_fault_alert i_sfa_smbus_fault_alert (.ref_clk, .rst, .bus_clock_in, .bus_data_in,
    .bus_data_out, .bus_data_oe, .alert_out, .alert_oe, .address_select, .fault_alert_mask,
    .thermal_overload, .undervoltage_lockout, .supply_overcurrent, .supply_undervoltage,
    .fault_status, .alert_return_address);
  sfa_host_model i_sfa_host_model (.ref_clk, .dev_data_oe(bus_data_oe),
    .bus_clock(bus_clock_in), .bus_data(bus_data_in));
  initial forever #5 ref_clk = ~ref_clk;
  task cyc(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task chk(input [95:0] name, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0s exp %h got %h", name, exp, got);
      end
    end
  endtask
  // transfer, stop, then let the sync pipeline settle
  task bus(input [7:0] a);
    begin
      i_sfa_host_model.xfer(a, 8'h00, ack, rd);
      i_sfa_host_model.stop;
      cyc(4);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // pointer read with no alert pending after start-up, foreign address ignored
  task t_reset;
    begin
      bus(8'h19);
      chk("alert", 8'h00, {7'h00, alert_oe});
      bus(8'h67);
      chk("no ack", 8'h00, {7'h00, ack});
      $display("t_reset done");
    end
  endtask
  // mask, a too-short overcurrent, then a qualified one
  task t_overcurrent;
    begin
      fault_alert_mask <= 1'b1;
      supply_overcurrent <= 4'h4;
      cyc(260);
      supply_overcurrent <= 4'h0;
      cyc(10);
      chk("masked", 8'h00, {fault_status[7:1], alert_oe});
      fault_alert_mask <= 1'b0;
      supply_overcurrent <= 4'h1;
      cyc(150);
      supply_overcurrent <= 4'h0;
      cyc(20);
      chk("short oc", 8'h00, {7'h00, alert_oe});
      supply_overcurrent <= 4'h1;
      cyc(230);
      supply_overcurrent <= 4'h0;
      cyc(20);
      chk("oc alert", 8'h01, {7'h00, alert_oe});
      chk("oc status", 8'h40, fault_status);
      $display("t_overcurrent done");
    end
  endtask
  // pointer read, then write and repeated start into a status read
  task t_reads;
    begin
      bus(8'h19);
      chk("ptr ack", 8'h01, {7'h00, ack});
      chk("ptr byte", 8'hA0, rd);
      chk("ptr alert", 8'h00, {7'h00, alert_oe});
      chk("ret addr", 8'hA0, alert_return_address);
      chk("kept", 8'h40, fault_status);
      i_sfa_host_model.xfer(8'hA0, 8'h00, ack, rd);
      bus(8'hA1);
      chk("rs ack", 8'h01, {7'h00, ack});
      chk("byte", 8'h40, rd);
      chk("cleared", 8'h00, fault_status);
      $display("t_reads done");
    end
  endtask
  // a fault that persists through service
  task t_persist;
    begin
      thermal_overload <= 1'b1;
      cyc(10);
      chk("cat", 8'h80, fault_status);
      bus(8'h19);
      chk("realert", 8'h01, {7'h00, alert_oe});
      supply_undervoltage <= 4'h8;
      cyc(10);
      chk("no reload", 8'h80, fault_status);
      bus(8'hA1);
      chk("cat byte", 8'h80, rd);
      chk("reload", 8'h88, fault_status);
      thermal_overload <= 1'b0;
      supply_undervoltage <= 4'h0;
      $display("t_persist done");
    end
  endtask
  // a lower rival wins the pointer read, then this slave is served
  task t_arbitrate;
    begin
      address_select <= 1'b1;
      i_sfa_host_model.rival = 8'h80;
      bus(8'h19);
      chk("lost byte", 8'h80, rd);
      chk("loser alert", 8'h01, {7'h00, alert_oe});
      i_sfa_host_model.rival = 8'hFF;
      bus(8'h19);
      chk("win byte", 8'hA4, rd);
      chk("ret addr", 8'hA4, alert_return_address);
      chk("alert off", 8'h00, {7'h00, alert_oe});
      $display("t_arbitrate done");
    end
  endtask
  // second reset in mid-run with a fault latched
  task t_rerst;
    begin
      undervoltage_lockout <= 1'b1;
      cyc(10);
      undervoltage_lockout <= 1'b0;
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(4);
      chk("rst status", 8'h00, fault_status);
      chk("rst alert", 8'h00, {7'h00, alert_oe});
      $display("t_rerst done");
    end
  endtask
  initial begin
    cyc(2);
    rst <= 1'b0;
    cyc(4);
    t_reset;
    t_overcurrent;
    t_reads;
    t_persist;
    t_arbitrate;
    t_rerst;
    report_and_stop;
  end
  // hang guard, well beyond the expected run
  initial begin
    cyc(20000);
    failures = failures + 1;
    report_and_stop;
  end
endmodule
